// ==== safe_state_fault_handler.sv ====
// Safe-state and fault reaction logic of the safety head unit
`timescale 1ns/1ns
module safe_state_fault_handler #(
  parameter int NUM_IN = fault_pkg::NUM_INPUTS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_IN-1:0] input_pins,
  input wire logic [NUM_IN-1:0] input_enable_cfg,
  input wire logic [NUM_IN-1:0] short_detect_cfg,
  input wire logic [NUM_IN-1:0] cross_detect_cfg,
  input wire logic [NUM_IN-1:0] short_fault_pins,
  input wire logic [NUM_IN-1:0] cross_fault_pins,
  input wire logic input_hw_fault,
  input wire logic output_hw_fault,
  input wire logic serious_hw_fault,
  input wire logic user_error,
  input wire logic overload,
  input wire logic overheat,
  input wire logic supply_fault,
  input wire logic param_fault,
  input wire logic comm_fault,
  input wire logic return_bridge_pin,
  input wire logic [fault_pkg::NUM_SOURCES-1:0] pulse_short_pins,
  input wire logic [fault_pkg::NUM_ZONES-1:0] zone_request,
  input wire logic ack,
  output logic [NUM_IN-1:0] input_image,
  output logic [fault_pkg::NUM_ZONES-1:0] zone_high_side,
  output logic module_zone_low_side,
  output logic valve_zone_low_side,
  output logic pulse_source_a,
  output logic pulse_source_b,
  output logic comm_enable,
  output logic self_test_enable,
  output logic failure_state,
  output logic diag_valid,
  output logic [7:0] diag_code,
  output logic [NUM_IN-1:0] diag_channel
);

  // Three-stage synchronisers for pin inputs
  localparam int NSYNC = 2 * NUM_IN + fault_pkg::NUM_SOURCES + 1;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] sync3_q;
  logic [NSYNC-1:0] stable_q;
  wire [NSYNC-1:0] raw_pins = {return_bridge_pin, pulse_short_pins,
    short_fault_pins, input_pins};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      stable_q <= '0;
    end
    else
    begin
      sync1_q <= raw_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      stable_q <= (sync2_q & sync3_q) | (stable_q & (sync2_q | sync3_q));
    end
  end

  // Field positions inside the synchroniser vector
  localparam int IN_LO = 0;
  localparam int SHORT_LO = IN_LO + NUM_IN;
  localparam int PSHORT_LO = SHORT_LO + NUM_IN;
  localparam int BRIDGE_POS = PSHORT_LO + fault_pkg::NUM_SOURCES;

  // Synchronised pin fields
  wire [NUM_IN-1:0] in_s = stable_q[IN_LO+:NUM_IN];
  wire [NUM_IN-1:0] short_s = stable_q[SHORT_LO+:NUM_IN];
  wire [fault_pkg::NUM_SOURCES-1:0] pshort_s =
    stable_q[PSHORT_LO+:fault_pkg::NUM_SOURCES];
  wire bridge_s = stable_q[BRIDGE_POS];

  // Cross faults come from the pulse checker on this clock
  wire [NUM_IN-1:0] short_hit = short_s & short_detect_cfg;
  wire [NUM_IN-1:0] cross_hit = cross_fault_pins & cross_detect_cfg;
  wire [NUM_IN-1:0] ext_hit = short_hit | cross_hit;

  // Serious error collection
  wire serious = serious_hw_fault | user_error | overload | overheat
    | supply_fault;

  // Module mode and latched fault state
  fault_pkg::mode_t mode_q;
  fault_pkg::mode_t mode_d;
  logic [NUM_IN-1:0] ch_fault_q;
  logic in_hw_q;
  logic out_hw_q;
  logic param_q;
  logic comm_q;
  logic bridge_q;
  logic [fault_pkg::NUM_SOURCES-1:0] psrc_off_q;

  wire any_err = (|ch_fault_q) | in_hw_q | out_hw_q | param_q | comm_q
    | bridge_q | (|psrc_off_q);

  // Mode transitions; failure is left only by reset
  always_comb
  begin
    case (mode_q)
      fault_pkg::ST_RUN:
        mode_d = serious ? fault_pkg::ST_FAILURE
          : (any_err ? fault_pkg::ST_ERROR : fault_pkg::ST_RUN);
      fault_pkg::ST_ERROR:
        mode_d = serious ? fault_pkg::ST_FAILURE
          : (any_err ? fault_pkg::ST_ERROR : fault_pkg::ST_RUN);
      fault_pkg::ST_FAILURE:
        mode_d = fault_pkg::ST_FAILURE;
      default:
        mode_d = fault_pkg::ST_FAILURE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mode_q <= fault_pkg::ST_RUN;
    else
      mode_q <= mode_d;
  end

  // Sticky flag step: a fault present in the acknowledge cycle stays set
  function automatic logic sticky(
    input logic set,
    input logic q,
    input logic clr
  );
    sticky = set | (q & ~clr);
  endfunction

  // Sticky fault latches: a new fault wins over acknowledge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ch_fault_q <= '0;
      in_hw_q <= 1'b0;
      out_hw_q <= 1'b0;
      param_q <= 1'b0;
      comm_q <= 1'b0;
      bridge_q <= 1'b0;
    end
    else
    begin
      ch_fault_q <= ext_hit | (ack ? '0 : ch_fault_q);
      in_hw_q <= sticky(input_hw_fault, in_hw_q, ack);
      out_hw_q <= sticky(output_hw_fault, out_hw_q, ack);
      param_q <= sticky(param_fault, param_q, ack);
      comm_q <= sticky(comm_fault, comm_q, ack);
      bridge_q <= sticky(bridge_s, bridge_q, ack);
    end
  end

  // Pulse sources switch off on short, restart only on acknowledge
  always_ff @(posedge clk)
  begin
    if (rst)
      psrc_off_q <= '0;
    else
      psrc_off_q <= pshort_s | (ack ? '0 : psrc_off_q);
  end

  // Image forcing decisions
  wire fail = (mode_q == fault_pkg::ST_FAILURE);
  wire all_safe = fail | serious | in_hw_q | input_hw_fault | param_q
    | param_fault | comm_q | comm_fault;
  wire [NUM_IN-1:0] image_d = all_safe ? '0
    : (in_s & input_enable_cfg & ~ch_fault_q & ~ext_hit);

  // Zone supply decisions
  // Parameter and link faults cut the zones in the same cycle as the image
  wire outputs_off = fail | serious | out_hw_q | output_hw_fault
    | bridge_q | param_q | param_fault
    | comm_q | comm_fault;
  wire [fault_pkg::NUM_ZONES-1:0] zones_d = outputs_off ? '0
    : zone_request;
  wire valve_on = |zones_d[fault_pkg::MOD_ZONE-1:0];
  wire mod_on = zones_d[fault_pkg::MOD_ZONE];

  // Bit of each pulse source in the shutdown latch
  localparam int SRC_A = 0;
  localparam int SRC_B = 1;

  // Input image register; reset shows the safe image
  always_ff @(posedge clk)
  begin
    if (rst)
      input_image <= '0;
    else
      input_image <= image_d;
  end

  // Zone switch registers; the module zone's rails switch together, the valve zones share one low-side rail
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      zone_high_side <= '0;
      module_zone_low_side <= 1'b0;
      valve_zone_low_side <= 1'b0;
    end
    else
    begin
      zone_high_side <= zones_d;
      module_zone_low_side <= mod_on;
      valve_zone_low_side <= valve_on;
    end
  end

  // Pulse source enables; a failed module stops both sources
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pulse_source_a <= 1'b0;
      pulse_source_b <= 1'b0;
    end
    else
    begin
      pulse_source_a <= ~psrc_off_q[SRC_A] & ~fail;
      pulse_source_b <= ~psrc_off_q[SRC_B] & ~fail;
    end
  end

  // Self-test and failure flags follow the next mode so they settle with the image; comm_enable follows the current mode
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      comm_enable <= 1'b0;
      self_test_enable <= 1'b0;
      failure_state <= 1'b0;
    end
    else
    begin
      comm_enable <= ~fail & ~out_hw_q & ~in_hw_q;
      self_test_enable <= (mode_d == fault_pkg::ST_RUN);
      failure_state <= (mode_d == fault_pkg::ST_FAILURE);
    end
  end

  // Event positions in the history, lowest index reported first
  localparam int EV_SERIOUS = 0;
  localparam int EV_IN_HW = 1;
  localparam int EV_OUT_HW = 2;
  localparam int EV_PARAM = 3;
  localparam int EV_COMM = 4;
  localparam int EV_BRIDGE = 5;
  localparam int EV_PULSE_A = 6;
  localparam int EV_PULSE_B = 7;
  localparam int NUM_EV = 8;

  // Isolates the lowest set bit, the event that wins this cycle
  function automatic logic [NUM_EV-1:0] lowest_event(
    input logic [NUM_EV-1:0] ev
  );
    lowest_event = ev & ~(ev - {{(NUM_EV-1){1'b0}}, 1'b1});
  endfunction

  // Rising edges of each fault event raise one diagnostic; the five serious sources share one event
  logic [NUM_IN-1:0] ch_prev_q;
  logic [NUM_EV-1:0] ev_prev_q;
  wire [NUM_EV-1:0] ev_now = {pshort_s, bridge_s, comm_fault, param_fault,
    output_hw_fault, input_hw_fault, serious};
  wire [NUM_EV-1:0] ev_new = ev_now & ~ev_prev_q;
  wire [NUM_EV-1:0] ev_taken = lowest_event(ev_new);
  wire ev_any = |ev_new;
  wire [NUM_IN-1:0] sh_new = short_hit & ~ch_prev_q;
  wire [NUM_IN-1:0] cr_new = cross_hit & ~ch_prev_q & ~short_hit;

  // Fixed priority selection; order must match lowest_event
  logic [7:0] code_sel;
  logic [NUM_IN-1:0] chan_sel;
  always_comb
  begin
    chan_sel = '0;
    if (ev_new[EV_SERIOUS])
      code_sel = fault_pkg::DIAG_SERIOUS;
    else if (ev_new[EV_IN_HW])
      code_sel = fault_pkg::DIAG_INPUT_HW;
    else if (ev_new[EV_OUT_HW])
      code_sel = fault_pkg::DIAG_OUTPUT_HW;
    else if (ev_new[EV_PARAM])
      code_sel = fault_pkg::DIAG_PARAM;
    else if (ev_new[EV_COMM])
      code_sel = fault_pkg::DIAG_COMM;
    else if (ev_new[EV_BRIDGE])
      code_sel = fault_pkg::DIAG_RETURN_BRIDGE;
    else if (ev_new[EV_PULSE_A])
      code_sel = fault_pkg::DIAG_PULSE_A;
    else if (ev_new[EV_PULSE_B])
      code_sel = fault_pkg::DIAG_PULSE_B;
    else if (|sh_new)
    begin
      code_sel = fault_pkg::DIAG_SHORT;
      chan_sel = sh_new;
    end
    else if (|cr_new)
    begin
      code_sel = fault_pkg::DIAG_CROSS;
      chan_sel = cr_new;
    end
    else
      code_sel = fault_pkg::DIAG_NONE;
  end

  // Channel history only advances when no module event is pending
  wire [NUM_IN-1:0] ch_taken = ev_any ? '0 : chan_sel;

  // Event history; a held fault is reported once, again after it falls
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ev_prev_q <= '0;
      ch_prev_q <= '0;
    end
    else
    begin
      ev_prev_q <= (ev_prev_q & ev_now) | ev_taken;
      ch_prev_q <= (ch_prev_q & ext_hit) | ch_taken;
    end
  end

  // Diagnostic word to the controller, valid for one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      diag_valid <= 1'b0;
      diag_code <= fault_pkg::DIAG_NONE;
      diag_channel <= '0;
    end
    else
    begin
      diag_valid <= (code_sel != fault_pkg::DIAG_NONE);
      diag_code <= code_sel;
      diag_channel <= chan_sel;
    end
  end

endmodule

// ==== fault_pkg.sv ====
// Constants and types of the safe-state fault handler
package fault_pkg;

  localparam int NUM_INPUTS = 8;
  localparam int NUM_ZONES = 4;
  localparam int NUM_SOURCES = 2;
  localparam int MOD_ZONE = 3;
  localparam int ERROR_LIMIT_HOURS = 72;

  // Diagnostic codes
  localparam logic [7:0] DIAG_NONE = 8'h00;
  localparam logic [7:0] DIAG_SHORT = 8'h01;
  localparam logic [7:0] DIAG_CROSS = 8'h02;
  localparam logic [7:0] DIAG_INPUT_HW = 8'h10;
  localparam logic [7:0] DIAG_OUTPUT_HW = 8'h11;
  localparam logic [7:0] DIAG_SERIOUS = 8'h20;
  localparam logic [7:0] DIAG_PARAM = 8'h30;
  localparam logic [7:0] DIAG_COMM = 8'h40;
  localparam logic [7:0] DIAG_RETURN_BRIDGE = 8'h50;
  localparam logic [7:0] DIAG_PULSE_A = 8'h60;
  localparam logic [7:0] DIAG_PULSE_B = 8'h61;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ERROR = 2'b01,
    ST_FAILURE = 2'b10
  } mode_t;
endpackage

// ==== safe_state_fault_handler_monitor.sv ====
// Port checker of the safe-state fault handler
`timescale 1ns/1ns
module safe_state_fault_handler_monitor #(
  parameter int NUM_IN = 8
)
(
  input logic clk,
  input logic rst,
  input logic input_hw_fault,
  input logic output_hw_fault,
  input logic serious_hw_fault,
  input logic user_error,
  input logic overload,
  input logic overheat,
  input logic supply_fault,
  input logic param_fault,
  input logic comm_fault,
  input logic [NUM_IN-1:0] input_image,
  input logic [fault_pkg::NUM_ZONES-1:0] zone_high_side,
  input logic module_zone_low_side,
  input logic valve_zone_low_side,
  input logic self_test_enable,
  input logic failure_state,
  input logic diag_valid,
  input logic [7:0] diag_code
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Any serious error
  wire serious = serious_hw_fault | user_error | overload | overheat |
    supply_fault;
  AST_SERIOUS: assert property (serious |=> failure_state)
    else $error("serious error without failure state");
  AST_STICKY: assert property (failure_state |=> failure_state)
    else $error("failure state left without reset");
  AST_FAIL_SAFE: assert property (failure_state |->
    !input_image && !zone_high_side && !self_test_enable)
    else $error("failure state not safe");
  AST_PARAM: assert property (param_fault |=>
    !input_image && !zone_high_side)
    else $error("parameter fault not safe");
  AST_PARAM_DIAG: assert property ($rose(param_fault) |->
    ##[1:12] (diag_valid && diag_code == fault_pkg::DIAG_PARAM))
    else $error("parameter fault not reported");
  AST_COMM: assert property (comm_fault |=> !input_image)
    else $error("comm fault image not zero");
  AST_IN_HW: assert property (input_hw_fault |=> !input_image)
    else $error("input hw fault image not zero");
  AST_OUT_HW: assert property (output_hw_fault |=> !zone_high_side)
    else $error("output hw fault zones on");
  AST_LOW_SIDE: assert property (
    module_zone_low_side == zone_high_side[fault_pkg::MOD_ZONE] &&
    valve_zone_low_side == |zone_high_side[2:0])
    else $error("low side switch mismatch");
  // Main scenarios
  cover property (diag_valid && diag_code == fault_pkg::DIAG_SHORT);
  cover property ($rose(failure_state));
  cover property (&zone_high_side);
endmodule
bind safe_state_fault_handler safe_state_fault_handler_monitor #(
  .NUM_IN(NUM_IN)
) u_safe_state_fault_handler_monitor (.clk, .rst, .input_hw_fault,
  .output_hw_fault, .serious_hw_fault, .user_error, .overload, .overheat,
  .supply_fault, .param_fault, .comm_fault, .input_image, .zone_high_side,
  .module_zone_low_side, .valve_zone_low_side, .self_test_enable,
  .failure_state, .diag_valid, .diag_code);

// ==== ctrl_model.sv ====
// Safety controller model: collects diagnostics, sends acknowledge
`timescale 1ns/1ns
module ctrl_model (
  input logic clk,
  input logic diag_valid,
  input logic [7:0] diag_code,
  input logic [7:0] diag_channel,
  output logic ack
);
  int n_diag = 0;
  logic [15:0] last_q = 16'h0000;
  initial ack = 1'b0;
  // Count each reported diagnostic, keep the last one
  always @(posedge clk)
  begin
    if (diag_valid === 1'b1)
    begin
      n_diag <= n_diag + 1;
      last_q <= {diag_code, diag_channel};
    end
  end
  // One-cycle acknowledge
  task automatic send_ack();
    @(negedge clk) ack = 1'b1;
    @(negedge clk) ack = 1'b0;
  endtask
endmodule

// ==== safe_state_fault_handler_tb_top.sv ====
// Testbench of the safe-state fault handler
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module safe_state_fault_handler_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] pins = 8'h00, sh = 8'h00, cr = 8'h00, img, dc, dch;
  logic [9:0] flt = 10'h000;
  logic [1:0] ps = 2'h0;
  logic [3:0] zreq = 4'h0, zhs;
  logic ack, mls, vls, pa, pb, ce, ste, fs, dv;
  int err_total = 0;
  int n_compared = 0;
  int n0;
  // Device under test
  safe_state_fault_handler u_safe_state_fault_handler (.clk(clk),
    .rst(rst), .input_pins(pins), .input_enable_cfg(8'hFF),
    .short_detect_cfg(8'hFF), .cross_detect_cfg(8'hFF),
    .short_fault_pins(sh), .cross_fault_pins(cr),
    .input_hw_fault(flt[0]), .output_hw_fault(flt[1]),
    .serious_hw_fault(flt[2]), .user_error(flt[3]), .overload(flt[4]),
    .overheat(flt[5]), .supply_fault(flt[6]), .param_fault(flt[7]),
    .comm_fault(flt[8]), .return_bridge_pin(flt[9]),
    .pulse_short_pins(ps), .zone_request(zreq), .ack(ack),
    .input_image(img), .zone_high_side(zhs), .module_zone_low_side(mls),
    .valve_zone_low_side(vls), .pulse_source_a(pa), .pulse_source_b(pb),
    .comm_enable(ce), .self_test_enable(ste), .failure_state(fs),
    .diag_valid(dv), .diag_code(dc), .diag_channel(dch));
  // Controller at the far side
  ctrl_model u_ctrl_model (.clk(clk), .diag_valid(dv), .diag_code(dc),
    .diag_channel(dch), .ack(ack));
  initial forever #10 clk = ~clk;
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    cyc(8);
  endtask
  // Wait for a new diagnostic, bounded
  task automatic wait_diag();
    for (int i = 0; i < 40 && u_ctrl_model.n_diag == n0; i++)
      @(negedge clk);
    if (u_ctrl_model.n_diag == n0)
      err_total++;
    cyc(2);
  endtask
  task automatic hit(int b);
    n0 = u_ctrl_model.n_diag;
    flt[b] = 1'b1;
    wait_diag();
  endtask
  task automatic clr();
    flt = 10'h000;
    ps = 2'h0;
    sh = 8'h00;
    cr = 8'h00;
    cyc(8);
    u_ctrl_model.send_ack();
    cyc(8);
  endtask
  task automatic t_run();
    pins = 8'hA5;
    zreq = 4'h8;
    cyc(8);
    `CHK(img, 8'hA5)
    `CHK({zhs, mls, vls}, 6'h22)
    zreq = 4'h5;
    pins = 8'hFF;
    cyc(8);
    `CHK({zhs, mls, vls}, 6'h15)
    `CHK({pa, pb, ste, ce, img}, 12'hFFF)
  endtask
  task automatic t_chan();
    n0 = u_ctrl_model.n_diag;
    sh = 8'h04;
    wait_diag();
    `CHK(u_ctrl_model.last_q, 16'h0104)
    `CHK(img, 8'hFB)
    clr();
    `CHK(img, 8'hFF)
    n0 = u_ctrl_model.n_diag;
    cr = 8'h20;
    wait_diag();
    `CHK(u_ctrl_model.last_q, 16'h0220)
    `CHK(img, 8'hDF)
    clr();
  endtask
  task automatic t_hw();
    hit(0);
    `CHK(u_ctrl_model.last_q[15:8], 8'h10)
    `CHK({img, ce, ste}, 10'h000)
    clr();
    zreq = 4'hF;
    hit(1);
    `CHK(u_ctrl_model.last_q[15:8], 8'h11)
    `CHK(zhs, 4'h0)
    clr();
    `CHK({zhs, img}, 12'hFFF)
  endtask
  task automatic t_param();
    hit(7);
    `CHK(u_ctrl_model.last_q[15:8], 8'h30)
    `CHK({img, zhs}, 12'h000)
    clr();
    hit(8);
    `CHK(u_ctrl_model.last_q[15:8], 8'h40)
    `CHK(img, 8'h00)
    clr();
    hit(9);
    `CHK(u_ctrl_model.last_q[15:8], 8'h50)
    clr();
  endtask
  task automatic t_pulse();
    for (int s = 0; s < 2; s++)
    begin
      n0 = u_ctrl_model.n_diag;
      ps[s] = 1'b1;
      wait_diag();
      `CHK(u_ctrl_model.last_q[15:8], 8'h60 + 8'(s))
      ps = 2'h0;
      cyc(8);
      `CHK({pa, pb}, s ? 2'b10 : 2'b01)
      clr();
      `CHK({pa, pb}, 2'b11)
    end
  endtask
  task automatic t_serious();
    for (int b = 2; b < 7; b++)
    begin
      hit(b);
      `CHK(u_ctrl_model.last_q[15:8], 8'h20)
      `CHK({fs, ste, img, zhs}, 14'h2000)
      clr();
      `CHK({fs, ste, img, zhs}, 14'h2000)
      do_reset();
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    do_reset();
    t_run();
    t_chan();
    t_hw();
    t_param();
    t_pulse();
    t_serious();
    end_of_test();
  end
  // Watchdog
  initial
  begin
    #400000;
    err_total++;
    end_of_test();
  end
endmodule
